// ===== logic/pfs_pkg.sv
`default_nettype none
package pfs_pkg;

  // ****************************************
  // clock and sequence timing
  // ****************************************
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int INIT_PULSE_PS      = 12600000;
  localparam int INIT_GAP_PS        = 110000000;
  localparam int INIT_PULSE_CYCLES  = (INIT_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_GAP_CYCLES    = (INIT_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W              = 20;

  // ****************************************
  // trap vector
  // ****************************************
  localparam logic [15:0] PFAIL_VECTOR = 16'h0018;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int          REG_AW      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_INT_STS = 8'h08;
  localparam logic [7:0]  OFS_INT_CLR = 8'h0C;
  localparam logic [7:0]  OFS_INT_EN  = 8'h10;

  // ctrl fields
  localparam int CTRL_OPT_LSB  = 0;
  localparam int CTRL_OVR_BIT  = 2;
  localparam logic [2:0] CTRL_RESET   = 3'h0;
  localparam logic [3:0] INT_EN_RESET = 4'h0;

  // status fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_POK_BIT   = 4;
  localparam int STS_DCOK_BIT  = 5;
  localparam int STS_JMP_LSB   = 6;
  localparam int STS_INIT_BIT  = 8;

  // interrupt event bits
  localparam int EV_W          = 4;
  localparam int EV_PWR_FAIL   = 0;
  localparam int EV_PWR_UP     = 1;
  localparam int EV_HALT_RST   = 2;
  localparam int EV_DC_LOST    = 3;

  // ****************************************
  // sequencer states, gray along the usual path
  // ****************************************
  typedef enum logic [3:0] {
    ST_DC_WAIT   = 4'h0,
    ST_INIT      = 4'h1,
    ST_GAP       = 4'h3,
    ST_POK_WAIT  = 4'h2,
    ST_START     = 4'h6,
    ST_RUN       = 4'h7,
    ST_TRAP_WAIT = 4'h5,
    ST_TRAP      = 4'h4,
    ST_DOWN      = 4'hC
  } pfs_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic power_good_in;
    logic dc_power_good_in;
  } pfs_pwr_t;

  typedef struct packed {
    logic processor_status_word;
    logic float_status_reg;
    logic float_exception_reg;
  } pfs_clear_t;

endpackage : pfs_pkg
`default_nettype wire

// ===== logic/pfs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // asynchronous inputs and filtered result
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1[i]       <= 1'b0;
        s2[i]       <= 1'b0;
        s3[i]       <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          sync_out[i] <= s3[i];
        end
      end
    end
  end

endmodule : pfs_sync
`default_nettype wire

// ===== logic/pfs_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pfs_timer #(
  parameter int W = 20
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic              expired
);
  logic [W-1:0] count;

  // expired is high while the count is spent; a load restarts it
  assign expired = (count == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (!expired) begin
      count <= count - 1'b1;
    end
  end

endmodule : pfs_timer
`default_nettype wire

// ===== logic/pfs_sequencer.sv
// What this block does and what it expects of the supply
// [R1] - bus initialize stays asserted while dc power good is low
// [R2] - dc power good rising clears status registers, then 12.6 us initialize pulse
// [R3] - supply drops power good to warn of failure; 4 ms reserve remains
// [R4] - initialize then negated 110 us; afterwards wait for power good
// [R5] - supply raises power good no sooner than 70 ms after dc power good
// [R6] - power good seen during the wait starts the power-up sequence
// [R7] - supply keeps power good at least 3.0 ms before any power-down
// [R8] - power good loss traps only after the current instruction finishes
// [R9] - power-fail trap takes its new program counter from location 24
// [R10] - a halt samples power good to choose the power-up path
// [R11] - halt with power good low clears registers, pulses initialize, waits again
// [R12] - power good returning with dc still good completes the power-up
// [R13] - four jumper-selected power-up options choose the start action
// [R14] - both power status inputs are synchronised before use
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pfs_sequencer
  import pfs_pkg::*;
#(
  parameter int INIT_GAP_CYC = INIT_GAP_CYCLES
) (
  // ahb-lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // power supply status pins
  input  wire pfs_pwr_t    pwr_in,
  // power-up option jumpers
  input  wire logic [1:0]  option_jumper,
  // processor core side
  input  wire logic        instr_done,
  input  wire logic        halt_exec,
  output logic             bus_initialize_out,
  output pfs_clear_t       clear_regs,
  output logic             trap_req,
  output logic [15:0]      trap_vector,
  output logic             start_req,
  output logic [1:0]       start_option,
  output logic             cpu_hold,
  // interrupt
  output logic             irq
);

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [3:0] pins_sync;
  logic       pok;
  logic       dcok;
  logic [1:0] jumper;

  pfs_sync #(.W(4)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({option_jumper, pwr_in.power_good_in, pwr_in.dc_power_good_in}),
    .sync_out (pins_sync)
  ); // [R14]

  assign dcok   = pins_sync[0];
  assign pok    = pins_sync[1];
  assign jumper = pins_sync[3:2];

  logic pok_d;
  logic dcok_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pok_d  <= 1'b0;
      dcok_d <= 1'b0;
    end else begin
      pok_d  <= pok;
      dcok_d <= dcok;
    end
  end

  wire pok_fall  = pok_d & ~pok;
  wire dcok_rise = dcok & ~dcok_d;
  wire dcok_fall = dcok_d & ~dcok;

  // ****************************************
  // timer
  // ****************************************
  pfs_state_t       state;
  pfs_state_t       next_state;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_value;
  logic             tmr_expired;

  pfs_timer #(.W(TMR_W)) u_timer (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .load       (tmr_load),
    .load_value (tmr_value),
    .expired    (tmr_expired)
  );

  // the timer is reloaded on entry to each timed state
  wire enter_init = (next_state == ST_INIT) && (state != ST_INIT);
  wire enter_gap  = (next_state == ST_GAP) && (state != ST_GAP);
  assign tmr_load  = enter_init | enter_gap;
  assign tmr_value = enter_init ? TMR_W'(INIT_PULSE_CYCLES - 1)
                                : TMR_W'(INIT_GAP_CYC - 1);

  // ****************************************
  // sequencer
  // ****************************************
  wire halt_pwr_low = halt_exec & ~pok; // [R10]

  always_comb begin
    next_state = state;
    case (state)
      ST_DC_WAIT: begin
        if (dcok) begin
          next_state = ST_INIT; // [R2]
        end
      end
      ST_INIT: begin
        if (tmr_expired) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr_expired) begin
          next_state = ST_POK_WAIT; // [R4]
        end
      end
      ST_POK_WAIT: begin
        if (pok) begin
          next_state = ST_START; // [R6] [R12]
        end
      end
      ST_START: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (halt_pwr_low) begin
          next_state = ST_INIT; // [R11]
        end else if (!pok) begin
          next_state = ST_TRAP_WAIT;
        end
      end
      ST_TRAP_WAIT: begin
        if (instr_done) begin
          next_state = ST_TRAP; // [R8]
        end
      end
      ST_TRAP: begin
        next_state = ST_DOWN;
      end
      ST_DOWN: begin
        if (halt_pwr_low) begin
          next_state = ST_INIT; // [R11]
        end else if (halt_exec) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_DC_WAIT;
      end
    endcase
    // dc loss overrides every state
    if (!dcok) begin
      next_state = ST_DC_WAIT; // [R1]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_DC_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // processor side outputs
  // ****************************************
  logic [2:0] ctrl;
  wire  [1:0] sel_option = ctrl[CTRL_OVR_BIT] ? ctrl[CTRL_OPT_LSB +: 2] : jumper;

  wire next_init  = (next_state == ST_DC_WAIT) || (next_state == ST_INIT); // [R1] [R2]
  wire next_clear = enter_init; // [R2] [R11]
  wire next_trap  = (next_state == ST_TRAP); // [R9]
  wire next_start = (next_state == ST_START); // [R13]
  wire next_hold  = (next_state != ST_RUN) && (next_state != ST_DOWN)
                    && (next_state != ST_TRAP_WAIT) && (next_state != ST_TRAP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_initialize_out <= 1'b1;
      clear_regs         <= '0;
      trap_req           <= 1'b0;
      trap_vector        <= PFAIL_VECTOR;
      start_req          <= 1'b0;
      start_option       <= 2'h0;
      cpu_hold           <= 1'b1;
    end else begin
      bus_initialize_out <= next_init;
      clear_regs         <= {3{next_clear}};
      trap_req           <= next_trap;
      trap_vector        <= PFAIL_VECTOR; // [R9]
      start_req          <= next_start;
      start_option       <= sel_option; // [R13]
      cpu_hold           <= next_hold;
    end
  end

  // ****************************************
  // interrupt events
  // ****************************************
  logic [EV_W-1:0] int_sts;
  logic [EV_W-1:0] int_en;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr_bits;

  assign ev[EV_PWR_FAIL] = pok_fall & (state == ST_RUN);
  assign ev[EV_PWR_UP]   = (next_state == ST_START) && (state != ST_START);
  assign ev[EV_HALT_RST] = halt_pwr_low & ((state == ST_RUN) | (state == ST_DOWN));
  assign ev[EV_DC_LOST]  = dcok_fall;

  // set wins over a clear in the same cycle
  wire [EV_W-1:0] next_int_sts = (int_sts & ~clr_bits) | ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_sts <= '0;
      irq     <= 1'b0;
    end else begin
      int_sts <= next_int_sts;
      irq     <= |(next_int_sts & int_en);
    end
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic              dp_valid;
  logic              dp_write;
  logic [REG_AW-1:0] dp_addr;

  wire               ap_take = hsel & hready & htrans[1];
  wire  [REG_AW-1:0] ap_addr = haddr[REG_AW-1:0];
  wire               wr_now  = dp_valid & dp_write;

  wire [31:0] status_word = {23'h000000, bus_initialize_out, jumper, dcok, pok,
                             state};

  wire [31:0] rd_mux =
    (ap_addr == OFS_CTRL)    ? {29'h00000000, ctrl} :
    (ap_addr == OFS_STATUS)  ? status_word :
    (ap_addr == OFS_INT_STS) ? {28'h0000000, int_sts} :
    (ap_addr == OFS_INT_EN)  ? {28'h0000000, int_en} :
                               32'h00000000;

  assign clr_bits = (wr_now && dp_addr == OFS_INT_CLR) ? hwdata[EV_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= '0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_valid  <= ap_take;
      dp_write  <= hwrite;
      dp_addr   <= ap_addr;
      hrdata    <= (ap_take && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= CTRL_RESET;
      int_en <= INT_EN_RESET;
    end else if (wr_now) begin
      if (dp_addr == OFS_CTRL) begin
        ctrl <= hwdata[2:0];
      end
      if (dp_addr == OFS_INT_EN) begin
        int_en <= hwdata[EV_W-1:0];
      end
    end
  end

endmodule : pfs_sequencer
`default_nettype wire

// ===== verification/pfs_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pfs_seq_asserts
  import pfs_pkg::*;
#(
  parameter int INIT_GAP_CYC = INIT_GAP_CYCLES
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // watched ports
  input wire pfs_pwr_t    pwr_in,
  input wire logic        instr_done,
  input wire logic        halt_exec,
  input wire logic        bus_initialize_out,
  input wire pfs_clear_t  clear_regs,
  input wire logic        trap_req,
  input wire logic [15:0] trap_vector,
  input wire logic        start_req,
  input wire logic        cpu_hold
);
  int pw_cnt;
  int gap_cnt;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // **********
  // helpers
  // **********
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_cnt  <= 0;
      gap_cnt <= 0;
    end else begin
      if (clear_regs != 3'h0) pw_cnt <= 1;
      else if (bus_initialize_out) pw_cnt <= pw_cnt + 1;
      gap_cnt <= bus_initialize_out ? 0 : gap_cnt + 1;
    end
  end
  // six samples cover the pin synchroniser latency
  sequence s_down_halt;
    (pwr_in.dc_power_good_in && !pwr_in.power_good_in) [*6] ##0 (halt_exec && !cpu_hold);
  endsequence
  sequence s_reinit;
    ##[0:2] (clear_regs == 3'h7) ##1 bus_initialize_out;
  endsequence
  AST_DC_LOW_INIT: assert property (!pwr_in.dc_power_good_in [*6] |-> bus_initialize_out)
    else $error("initialize low while dc power is low");
  AST_CLEAR_ALL: assert property (clear_regs != 3'h0 |-> clear_regs == 3'h7 && bus_initialize_out)
    else $error("partial clear or clear without initialize");
  AST_INIT_WIDTH: assert property ($fell(bus_initialize_out) |-> pw_cnt inside {[INIT_PULSE_CYCLES-1:INIT_PULSE_CYCLES+1]})
    else $error("initialize pulse width wrong");
  AST_GAP_WIDTH: assert property (start_req |-> !bus_initialize_out && gap_cnt >= INIT_GAP_CYC - 1)
    else $error("start before the initialize gap ended");
  AST_START_POK: assert property (start_req |-> $past(pwr_in.power_good_in, 3))
    else $error("start without power good");
  AST_START_RUN: assert property (start_req |-> ##[0:1] !cpu_hold)
    else $error("core still held after start");
  AST_TRAP_DONE: assert property (trap_req |-> $past(instr_done) || $past(instr_done, 2))
    else $error("trap before instruction completed");
  AST_TRAP_PULSE: assert property (trap_req |=> !trap_req)
    else $error("trap request longer than one cycle");
  AST_TRAP_VECTOR: assert property (trap_vector == PFAIL_VECTOR)
    else $error("trap vector wrong");
  AST_HALT_REINIT: assert property (s_down_halt |-> s_reinit)
    else $error("halt with power low did not reinitialize");
endmodule : pfs_seq_asserts
`default_nettype wire

// ===== verification/pfs_supply.sv
`timescale 1ns/10ps
`default_nettype none
module pfs_supply
  import pfs_pkg::*;
#(
  parameter int POK_DLY  = 100,
  parameter int POK_HOLD = 50
) (
  // clock
  input  wire logic     hclk,
  // bench commands
  input  wire logic     dc_cmd,
  input  wire logic     pok_cmd,
  // status pins
  output var  pfs_pwr_t pwr
);
  int dc_cnt;
  int pok_cnt;
  // delays scaled down to keep runs short; dc stays up after power good drops
  always_ff @(posedge hclk) begin
    if (!dc_cmd) begin
      pwr     <= '0;
      dc_cnt  <= 0;
      pok_cnt <= 0;
    end else begin
      pwr.dc_power_good_in <= 1'b1;
      dc_cnt  <= (dc_cnt < POK_DLY) ? dc_cnt + 1 : dc_cnt;
      pok_cnt <= pwr.power_good_in ? pok_cnt + 1 : 0;
      if (pok_cmd && dc_cnt >= POK_DLY) pwr.power_good_in <= 1'b1;
      else if (!pok_cmd && pok_cnt >= POK_HOLD) pwr.power_good_in <= 1'b0;
    end
  end
endmodule : pfs_supply
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import pfs_pkg::*;
;
  localparam int GAP = 20;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  option_jumper = 2'h0;
  logic        instr_done = 1'b0;
  logic        halt_exec = 1'b0;
  logic        dc_cmd = 1'b0;
  logic        pok_cmd = 1'b0;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, bus_initialize_out, trap_req, start_req, cpu_hold, irq;
  logic [15:0] trap_vector;
  logic [1:0]  start_option;
  pfs_pwr_t    pwr_in;
  pfs_clear_t  clear_regs;
  int          error_cnt = 0;
  int          comparisons = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  pfs_sequencer #(.INIT_GAP_CYC(GAP)) pfs_sequencer_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pwr_in,
    .option_jumper, .instr_done, .halt_exec, .bus_initialize_out, .clear_regs, .trap_req,
    .trap_vector, .start_req, .start_option, .cpu_hold, .irq);
  pfs_supply pfs_supply_inst (.hclk, .dc_cmd, .pok_cmd, .pwr(pwr_in));
  // **********
  // tasks
  // **********
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task power_up(input logic [1:0] opt);
    int n;
    logic [31:0] rd;
    n = 0;
    while (clear_regs !== 3'h7 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    check(clear_regs, 3'h7);
    n = 0;
    while (bus_initialize_out === 1'b1 && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    check(n, INIT_PULSE_CYCLES);
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd[STS_STATE_LSB +: 4], ST_GAP);
    repeat (GAP) @(posedge hclk);
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd[STS_STATE_LSB +: 4], ST_POK_WAIT);
    pok_cmd <= 1'b1;
    n = 0;
    while (start_req !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(start_req, 1'b1);
    check(start_option, opt);
    @(posedge hclk);
    check(cpu_hold, 1'b0);
    ahb(1'b0, OFS_INT_STS, 32'h0, rd);
    check(rd[EV_PWR_UP], 1'b1);
  endtask : power_up
  task t_irq;
    logic [31:0] rd;
    ahb(1'b1, OFS_INT_EN, 32'hF, rd);
    repeat (2) @(posedge hclk);
    check(irq, 1'b1);
    ahb(1'b1, OFS_INT_EN, 32'h0, rd);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    ahb(1'b1, OFS_INT_EN, 32'hF, rd);
    ahb(1'b1, OFS_INT_CLR, 32'hF, rd);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    ahb(1'b0, OFS_INT_EN, 32'h0, rd);
    check(rd, 32'hF);
    ahb(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
  endtask : t_irq
  task t_fail(input logic [1:0] opt);
    int n;
    logic [31:0] rd;
    // clear the sticky bits left by earlier scenarios so the checks below can fail
    ahb(1'b1, OFS_INT_CLR, 32'hF, rd);
    option_jumper <= opt;
    pok_cmd <= 1'b0;
    n = 0;
    while (pwr_in.power_good_in === 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    repeat (10) @(posedge hclk);
    check(trap_req, 1'b0);
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd[STS_STATE_LSB +: 4], ST_TRAP_WAIT);
    ahb(1'b0, OFS_INT_STS, 32'h0, rd);
    check(rd[EV_PWR_FAIL], 1'b1);
    instr_done <= 1'b1;
    @(posedge hclk);
    instr_done <= 1'b0;
    n = 0;
    while (trap_req !== 1'b1 && n < 8) begin
      @(posedge hclk);
      n++;
    end
    check(trap_req, 1'b1);
    check(trap_vector, PFAIL_VECTOR);
    repeat (4) @(posedge hclk);
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
    power_up(opt);
    ahb(1'b0, OFS_INT_STS, 32'h0, rd);
    check(rd[EV_HALT_RST], 1'b1);
  endtask : t_fail
  task t_halt_high;
    logic [31:0] rd;
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd[STS_STATE_LSB +: 4], ST_RUN);
    // software override of the jumpers, jumpers stand at 3 here
    ahb(1'b1, OFS_CTRL, 32'h5, rd);
    repeat (2) @(posedge hclk);
    check(start_option, 2'h1);
    ahb(1'b0, OFS_CTRL, 32'h0, rd);
    check(rd, 32'h5);
    ahb(1'b1, OFS_CTRL, 32'h0, rd);
    repeat (2) @(posedge hclk);
    check(start_option, 2'h3);
  endtask : t_halt_high
  task t_dc_lost;
    logic [31:0] rd;
    dc_cmd <= 1'b0;
    repeat (8) @(posedge hclk);
    check(bus_initialize_out, 1'b1);
    ahb(1'b0, OFS_INT_STS, 32'h0, rd);
    check(rd[EV_DC_LOST], 1'b1);
  endtask : t_dc_lost
  // **********
  // main
  // **********
  initial begin
    repeat (3) @(posedge hclk);
    check(bus_initialize_out, 1'b1);
    check(trap_vector, PFAIL_VECTOR);
    hresetn <= 1'b1;
    dc_cmd <= 1'b1;
    power_up(2'h0);
    t_irq;
    for (int j = 1; j < 4; j++) t_fail(j[1:0]);
    t_halt_high;
    t_dc_lost;
    end_sim;
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
endmodule : tb
bind pfs_sequencer pfs_seq_asserts #(.INIT_GAP_CYC(INIT_GAP_CYC)) pfs_seq_asserts_inst (
  .hclk, .hresetn, .pwr_in, .instr_done, .halt_exec, .bus_initialize_out, .clear_regs,
  .trap_req, .trap_vector, .start_req, .cpu_hold);
`default_nettype wire
